//--- hdl/drive_terminal_function_map.sv
// terminal function map top: apb registers, input mapping, output selection
//
// Function
// - input code 50 active adds the stored offset to output frequency
// - code 51 active forces frequency and run sources to terminals
// - code 52 active keeps output stage precharged for instant start
// - code 53 selects second motor set, switchable in stop or run
// - safe-stop input, code 64, active shuts off motor output
// - safe-stop not user assignable; assigned by hardware safe-stop switch
// - switch on: t3 safe stop, t4 reset, t5 none; off after: t3 none
// - each output has a 12-way function selector, defaults 01 and 05
// - polarity conversion for both outputs, independently
// - open-collector polarity default 00 normally open; 01 inverts
// - relay polarity same encoding, default 01 normally closed
// - function 01 asserts only at set frequency, not ramping or off
// - function 05 asserts while an uncleared alarm exists
`timescale 1ns/1ps
module drive_terminal_function_map
    import term_map_pkg::*;
(
    input  wire logic                  core_clk,            // 125 MHz clock
    input  wire logic                  nrst,                // async reset, low
    input  wire logic                  psel,                // apb select
    input  wire logic                  penable,             // apb enable
    input  wire logic                  pwrite,              // apb write
    input  wire logic [ADDR_W-1:0]     paddr,               // apb address
    input  wire logic [31:0]           pwdata,              // apb write data
    output logic      [31:0]           prdata,              // apb read data
    output logic                       pready,              // apb ready
    output logic                       pslverr,             // apb error
    input  wire logic [4:0]            terminalIn,          // terminals 1..5, high = on
    input  wire logic                  safe_stop_switch,    // hardware switch
    input  wire logic                  outputRunning,       // motor output on
    input  wire logic                  rampActive,          // accel or decel
    input  wire logic                  alarmActive,         // alarm occurred, uncleared
    input  wire logic [NUM_OUT_FUNC-1:0] otherFuncs,        // other output functions
    output logic      [15:0]           freqOffset,          // offset added to freq
    output logic                       useTerminalSource,   // sources from terminals
    output logic      [1:0]            frequency_source_select, // effective freq source
    output logic      [1:0]            run_source_select,   // effective run source
    output logic                       prechargeHold,       // keep stage charged
    output logic                       second_motor_select, // second parameter set
    output logic                       motorOff,            // shut off motor output
    output logic                       forward_run_input,   // forward run
    output logic                       reverse_run_input,   // reverse run
    output logic                       trip_reset_input,    // trip reset
    output logic                       ocOut,               // open-collector level
    output logic                       relayOut             // alarm relay level
);
    localparam logic [1:0] SRC_TERMINAL = 2'h1;

    logic [7:0]  termCode_ff [NUM_PROG_TERM];
    logic [15:0] add_frequency_offset_ff;
    logic [1:0]  freqSrcCfg_ff;
    logic [1:0]  runSrcCfg_ff;
    out_cfg_s    outCfg_ff;
    logic        switchSeen_ff;
    core_ctl_s   ctl;
    logic [7:0]  effCode [NUM_PROG_TERM];
    logic [NUM_PROG_TERM-1:0] hitAdd, hitForce, hitReady, hitSecond, hitStop;
    logic [NUM_OUT_FUNC-1:0] funcs;
    logic        ocLevel, relayLevel;
    logic        at_speed_flag, alarm_flag;
    logic        wrEn, rdEn, addrOk;
    logic [31:0] nxt_prdata;

    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && penable && !pwrite;

    // register writes; safe-stop code is refused from software
    // not user assignable
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            termCode_ff[0] <= RST_T3_CODE;
            termCode_ff[1] <= RST_T4_CODE;
            termCode_ff[2] <= RST_T5_CODE;
        end
        else if (wrEn && paddr == OFS_IN_ASSIGN)
        begin
            for (int i = 0; i < NUM_PROG_TERM; i++)
            begin
                if (pwdata[8*i +: 8] != CODE_SAFE_STOP)
                    termCode_ff[i] <= pwdata[8*i +: 8];
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            outCfg_ff.ocFunc    <= RST_OC_FUNC;
            outCfg_ff.ocPol     <= RST_OC_POL;
            outCfg_ff.relayFunc <= RST_RLY_FUNC;
            outCfg_ff.relayPol  <= RST_RLY_POL;
        end
        else if (wrEn && paddr == OFS_OUT_CFG)
        begin
            outCfg_ff.ocFunc    <= pwdata[OC_FUNC_LSB +: 4];
            outCfg_ff.ocPol     <= pwdata[OC_POL_BIT];
            outCfg_ff.relayFunc <= pwdata[RLY_FUNC_LSB +: 4];
            outCfg_ff.relayPol  <= pwdata[RLY_POL_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            add_frequency_offset_ff <= RST_ADD_OFFSET;
        else if (wrEn && paddr == OFS_ADD_OFFSET)
            add_frequency_offset_ff <= pwdata[15:0];
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            freqSrcCfg_ff <= 2'h0;
            runSrcCfg_ff  <= 2'h0;
        end
        else if (wrEn && paddr == OFS_SRC_SEL)
        begin
            freqSrcCfg_ff <= pwdata[1:0];
            runSrcCfg_ff  <= pwdata[9:8];
        end
    end

    // remembers that the switch was on, so t3 stays unused afterwards
    // switch-on history
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            switchSeen_ff <= 1'b0;
        else if (safe_stop_switch)
            switchSeen_ff <= 1'b1;
    end

    always_comb
    begin
        effCode[0] = termCode_ff[0];
        effCode[1] = termCode_ff[1];
        effCode[2] = termCode_ff[2];
        if (safe_stop_switch)
        begin
            effCode[0] = CODE_SAFE_STOP;
            effCode[1] = RST_T5_CODE;
            effCode[2] = CODE_NONE;
        end
        else if (switchSeen_ff)
        begin
            effCode[0] = CODE_NONE;
            effCode[1] = RST_T5_CODE;
            effCode[2] = CODE_NONE;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PROG_TERM; g++)
        begin : gTerm
            // safe stop is a 1b contact: open contact means stop
            input_decode uDec (
                .code      (effCode[g]),
                .active    ((safe_stop_switch && g == 0) ? !terminalIn[2] : terminalIn[g+2]),
                .addFreq   (hitAdd[g]),
                .forceTerm (hitForce[g]),
                .ready     (hitReady[g]),
                .secondMtr (hitSecond[g]),
                .safeStop  (hitStop[g])
            );
        end
    endgenerate

    // trip reset comes from whichever terminal holds that code
    always_comb
    begin
        ctl.forwardRun          = terminalIn[0];
        ctl.reverseRun          = terminalIn[1];
        ctl.tripReset           = 1'b0;
        for (int i = 0; i < NUM_PROG_TERM; i++)
        begin
            if (effCode[i] == RST_T5_CODE && terminalIn[i+2])
                ctl.tripReset = 1'b1;
        end
        ctl.addFreqEn           = |hitAdd;
        ctl.forceTerminalSource = |hitForce;
        ctl.readyPrecharge      = |hitReady;
        ctl.secondMotorSelect   = |hitSecond;
        ctl.safeStop            = |hitStop;
    end

    always_comb
    begin
        at_speed_flag = outputRunning && !rampActive;
        alarm_flag    = alarmActive;
        funcs         = otherFuncs;
        funcs[OFUNC_AT_SPEED] = at_speed_flag;
        funcs[OFUNC_ALARM]    = alarm_flag;
    end

    output_select uOcSel (
        .funcs (funcs),
        .sel   (outCfg_ff.ocFunc),
        .pol   (outCfg_ff.ocPol),
        .level (ocLevel)
    );

    output_select uRlySel (
        .funcs (funcs),
        .sel   (outCfg_ff.relayFunc),
        .pol   (outCfg_ff.relayPol),
        .level (relayLevel)
    );

    // registered core-facing outputs
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            freqOffset              <= 16'h0000;
            useTerminalSource       <= 1'b0;
            frequency_source_select <= 2'h0;
            run_source_select       <= 2'h0;
            prechargeHold           <= 1'b0;
            second_motor_select     <= 1'b0;
            motorOff                <= 1'b1;
            forward_run_input       <= 1'b0;
            reverse_run_input       <= 1'b0;
            trip_reset_input        <= 1'b0;
            ocOut                   <= 1'b1;
            relayOut                <= 1'b1;
        end
        else
        begin
            freqOffset <= ctl.addFreqEn ? add_frequency_offset_ff : 16'h0000;
            useTerminalSource       <= ctl.forceTerminalSource;
            frequency_source_select <= ctl.forceTerminalSource ? SRC_TERMINAL : freqSrcCfg_ff;
            run_source_select       <= ctl.forceTerminalSource ? SRC_TERMINAL : runSrcCfg_ff;
            prechargeHold           <= ctl.readyPrecharge;
            second_motor_select     <= ctl.secondMotorSelect;
            motorOff                <= ctl.safeStop;
            forward_run_input       <= ctl.forwardRun;
            reverse_run_input       <= ctl.reverseRun;
            trip_reset_input        <= ctl.tripReset;
            ocOut                   <= ocLevel;
            relayOut                <= relayLevel;
        end
    end

    // apb read mux; no wait states
    always_comb
    begin
        addrOk     = 1'b1;
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            OFS_IN_ASSIGN:  nxt_prdata = {8'h00, effCode[2], effCode[1], effCode[0]};
            OFS_OUT_CFG:    nxt_prdata = {19'h0, outCfg_ff.relayPol, outCfg_ff.relayFunc,
                                          3'h0, outCfg_ff.ocPol, outCfg_ff.ocFunc};
            OFS_ADD_OFFSET: nxt_prdata = {16'h0000, add_frequency_offset_ff};
            OFS_SRC_SEL:    nxt_prdata = {22'h0, runSrcCfg_ff, 6'h0, freqSrcCfg_ff};
            OFS_STATUS:     nxt_prdata = {24'h0, switchSeen_ff, safe_stop_switch,
                                          relayOut, ocOut, motorOff, second_motor_select,
                                          prechargeHold, useTerminalSource};
            OFS_CORE_IN:    nxt_prdata = {27'h0, terminalIn};
            default:        addrOk = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addrOk;
            prdata  <= (psel && !penable && !pwrite) ? nxt_prdata : prdata;
        end
    end

    logic unusedRd;
    assign unusedRd = rdEn;
endmodule

//--- hdl/input_decode.sv
// decodes one programmable input terminal into function hits
`timescale 1ns/1ps
module input_decode
    import term_map_pkg::*;
(
    input  wire logic [7:0] code,       // assigned option code
    input  wire logic       active,     // terminal level, high = on
    output logic            addFreq,    // code 50 hit
    output logic            forceTerm,  // code 51 hit
    output logic            ready,      // code 52 hit
    output logic            secondMtr,  // code 53 hit
    output logic            safeStop    // code 64 hit
);
    always_comb
    begin
        addFreq   = active && (code == CODE_ADD_FREQ);
        forceTerm = active && (code == CODE_FORCE_TERM);
        ready     = active && (code == CODE_READY);
        secondMtr = active && (code == CODE_SECOND_MTR);
        safeStop  = active && (code == CODE_SAFE_STOP);
    end
endmodule

//--- hdl/output_select.sv
// picks one output function and applies the polarity conversion
`timescale 1ns/1ps
module output_select
    import term_map_pkg::*;
(
    input  wire logic [NUM_OUT_FUNC-1:0] funcs,   // logical state of each function
    input  wire logic [3:0]              sel,     // function selector
    input  wire logic                    pol,     // polarity selector
    output logic                         level    // driven level
);
    logic chosen;

    always_comb
    begin
        // out-of-range selector reads as inactive
        chosen = (sel < 4'(NUM_OUT_FUNC)) ? funcs[sel] : 1'b0;
        level  = (pol == POL_NORM_CLOSE) ? chosen : ~chosen;
    end
endmodule

//--- include/term_map_pkg.sv
// shared constants, register map and carriers for the terminal function map
package term_map_pkg;

    localparam int unsigned ADDR_W = 12;

    // register byte offsets
    localparam logic [11:0] OFS_IN_ASSIGN  = 12'h000;
    localparam logic [11:0] OFS_OUT_CFG    = 12'h004;
    localparam logic [11:0] OFS_ADD_OFFSET = 12'h008;
    localparam logic [11:0] OFS_SRC_SEL    = 12'h00C;
    localparam logic [11:0] OFS_STATUS     = 12'h010;
    localparam logic [11:0] OFS_CORE_IN    = 12'h014;

    // input option codes
    localparam logic [7:0] CODE_ADD_FREQ   = 8'h32;  // 50
    localparam logic [7:0] CODE_FORCE_TERM = 8'h33;  // 51
    localparam logic [7:0] CODE_READY      = 8'h34;  // 52
    localparam logic [7:0] CODE_SECOND_MTR = 8'h35;  // 53
    localparam logic [7:0] CODE_SAFE_STOP  = 8'h40;  // 64
    localparam logic [7:0] CODE_NONE       = 8'hFF;  // 255

    // output function codes, 12 of them
    localparam int unsigned NUM_OUT_FUNC  = 12;
    localparam logic [3:0]  OFUNC_AT_SPEED = 4'h1;
    localparam logic [3:0]  OFUNC_ALARM    = 4'h5;

    // polarity codes
    localparam logic POL_NORM_OPEN  = 1'b0;
    localparam logic POL_NORM_CLOSE = 1'b1;

    // reset values
    localparam logic [3:0]  RST_OC_FUNC    = OFUNC_AT_SPEED;
    localparam logic [3:0]  RST_RLY_FUNC   = OFUNC_ALARM;
    localparam logic        RST_OC_POL     = POL_NORM_OPEN;
    localparam logic        RST_RLY_POL    = POL_NORM_CLOSE;
    localparam logic [15:0] RST_ADD_OFFSET = 16'h0000;
    localparam logic [7:0]  RST_T3_CODE    = 8'h01;  // speed select bit 0
    localparam logic [7:0]  RST_T4_CODE    = 8'h02;  // speed select bit 1
    localparam logic [7:0]  RST_T5_CODE    = 8'h12;  // trip reset

    // field positions in OUT_CFG
    localparam int unsigned OC_FUNC_LSB  = 0;
    localparam int unsigned OC_POL_BIT   = 4;
    localparam int unsigned RLY_FUNC_LSB = 8;
    localparam int unsigned RLY_POL_BIT  = 12;

    localparam int unsigned NUM_PROG_TERM = 3;  // terminals 3..5

    typedef struct packed {
        logic forwardRun;
        logic reverseRun;
        logic tripReset;
        logic addFreqEn;
        logic forceTerminalSource;
        logic readyPrecharge;
        logic secondMotorSelect;
        logic safeStop;
    } core_ctl_s;

    typedef struct packed {
        logic [3:0] ocFunc;
        logic       ocPol;
        logic [3:0] relayFunc;
        logic       relayPol;
    } out_cfg_s;

endpackage

//--- verification/field_contacts.sv
// field contacts and motor status feeding the drive terminals
`timescale 1ns/1ps
module field_contacts
(
    input  wire logic        core_clk,   // clock
    input  wire logic [20:0] want,       // requested contact and status states
    output logic      [20:0] field       // wiring levels seen by the drive
);
    // contacts settle one cycle after the request, never in the same edge
    always_ff @(posedge core_clk)
        field <= want;
endmodule

//--- verification/tb_drive_terminal_function_map.sv
// self-checking bench for the terminal function map
`timescale 1ns/1ps
module tb_drive_terminal_function_map
    import term_map_pkg::*;
();
    logic        core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, c;
    logic        pready, pslverr, useTerminalSource, prechargeHold, second_motor_select;
    logic        motorOff, forward_run_input, reverse_run_input, trip_reset_input;
    logic        ocOut, relayOut;
    logic [15:0] freqOffset, off;
    logic [1:0]  frequency_source_select, run_source_select;
    logic [20:0] want = 21'h0, field, v;
    logic [11:0] fn;
    logic [3:0]  ocs, rls;
    logic [32:0] expQ[$];
    integer      seed = 32'hC2E1D711;
    int          failures = 0, n_checks = 0, cyc = 0, i;

    drive_terminal_function_map u_dut (.core_clk(core_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .terminalIn(field[4:0]),
        .safe_stop_switch(field[5]), .outputRunning(field[6]), .rampActive(field[7]),
        .alarmActive(field[8]), .otherFuncs(field[20:9]), .freqOffset(freqOffset),
        .useTerminalSource(useTerminalSource), .frequency_source_select(frequency_source_select),
        .run_source_select(run_source_select), .prechargeHold(prechargeHold),
        .second_motor_select(second_motor_select), .motorOff(motorOff),
        .forward_run_input(forward_run_input), .reverse_run_input(reverse_run_input),
        .trip_reset_input(trip_reset_input), .ocOut(ocOut), .relayOut(relayOut));
    field_contacts u_field (.core_clk(core_clk), .want(want), .field(field));

    always #4 core_clk = ~core_clk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic report(input string w, input logic [32:0] e, input logic [32:0] g);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic cmp_read(input logic [32:0] e, input logic [32:0] g);
        report("read data", e, g);
    endtask

    task automatic cmp_lvl(input string w, input logic [15:0] e, input logic [15:0] g);
        report(w, {17'h0, e}, {17'h0, g});
    endtask

    // setup, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // no local limit: a missing pready is caught by the cycle ceiling
        while (pready !== 1'b1)
            @(posedge core_clk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        expQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic set(input logic [20:0] x);
        @(posedge core_clk);
        want <= x;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    function automatic logic lvl(input logic [11:0] f, input logic [3:0] s, input logic p);
        return p ~^ ((s < 4'hC) && f[s]);
    endfunction

    // read answers are taken at the edge that samples pready
    always @(posedge core_clk)
        if (psel && penable && pready === 1'b1 && !pwrite)
            cmp_read(expQ.size() > 0 ? expQ.pop_front() : 33'h1FFFFFFFF, {pslverr, prdata});

    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        rd(OFS_IN_ASSIGN, {1'b0, 32'h00120201});
        rd(OFS_OUT_CFG, {1'b0, 32'h00001501});
        rd(12'h018, {1'b1, 32'h0});
        $display("test reset values done");
        off = $random(seed) | 1;
        apb(1'b1, OFS_ADD_OFFSET, {16'h0, off});
        apb(1'b1, OFS_SRC_SEL, 32'h00000302);
        apb(1'b1, OFS_IN_ASSIGN, 32'h00343332);
        for (i = 0; i < 16; i++)
        begin
            v = $random(seed);
            v[5] = 1'b0;
            set(v);
            cmp_lvl("offset", v[2] ? off : 16'h0, freqOffset);
            cmp_lvl("forced", v[3], useTerminalSource);
            cmp_lvl("sources", v[3] ? 4'h5 : 4'hB, {frequency_source_select, run_source_select});
            cmp_lvl("precharge", v[4], prechargeHold);
            cmp_lvl("fwd rev", v[1:0], {reverse_run_input, forward_run_input});
            cmp_lvl("motor off", 1'b0, motorOff);
        end
        apb(1'b1, OFS_IN_ASSIGN, 32'h00343335);
        for (i = 0; i < 4; i++)
        begin
            set({14'h0, i[1], 3'h0, i[0], 2'h0});
            cmp_lvl("second set", i[0], second_motor_select);
        end
        apb(1'b1, OFS_IN_ASSIGN, 32'h00403335);
        rd(OFS_IN_ASSIGN, {1'b0, 32'h00343335});
        $display("test input functions done");
        for (i = 0; i < 24; i++)
        begin
            v = $random(seed);
            v[5] = 1'b0;
            c = $random(seed);
            ocs = (i % 3 == 0) ? OFUNC_AT_SPEED : (i % 3 == 1) ? OFUNC_ALARM : c[3:0];
            rls = (i % 3 == 0) ? OFUNC_ALARM : (i % 3 == 1) ? OFUNC_AT_SPEED : c[11:8];
            apb(1'b1, OFS_OUT_CFG, {19'h0, c[12], rls, 3'h0, c[4], ocs});
            set(v);
            fn = {v[20:15], v[8], v[13:11], v[6] & ~v[7], v[9]};
            cmp_lvl("oc level", lvl(fn, ocs, c[4]), ocOut);
            cmp_lvl("relay level", lvl(fn, rls, c[12]), relayOut);
        end
        $display("test output selection done");
        for (i = 0; i < 4; i++)
        begin
            set({15'h0, 1'b1, 1'b0, i[1], i[0], 2'b01});
            cmp_lvl("motor off", !i[0], motorOff);
            cmp_lvl("trip reset", i[1], trip_reset_input);
            cmp_lvl("fwd rev", 2'b01, {reverse_run_input, forward_run_input});
        end
        rd(OFS_IN_ASSIGN, {1'b0, 32'h00FF1240});
        set({15'h0, 1'b0, 5'b11100});
        cmp_lvl("motor off", 1'b0, motorOff);
        cmp_lvl("trip reset", 1'b1, trip_reset_input);
        cmp_lvl("precharge", 1'b0, prechargeHold);
        rd(OFS_IN_ASSIGN, {1'b0, 32'h00FF12FF});
        $display("test safe stop switch done");
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        rd(OFS_IN_ASSIGN, {1'b0, 32'h00120201});
        $display("test second reset done");
        repeat (2) @(posedge core_clk);
        tally_and_finish();
    end
endmodule

//--- verification/term_map_properties.sv
// concurrent checks on the terminal function map ports
`timescale 1ns/1ps
module term_map_checker
    import term_map_pkg::*;
(
    input wire logic                    core_clk,                // clock
    input wire logic                    nrst,                    // async reset, low
    input wire logic                    psel,                    // apb select
    input wire logic                    penable,                 // apb enable
    input wire logic                    pwrite,                  // apb write
    input wire logic [ADDR_W-1:0]       paddr,                   // apb address
    input wire logic [31:0]             pwdata,                  // apb write data
    input wire logic                    pready,                  // apb ready
    input wire logic                    pslverr,                 // apb error
    input wire logic [4:0]              terminalIn,              // terminals 1..5
    input wire logic                    safe_stop_switch,        // hardware switch
    input wire logic                    outputRunning,           // motor output on
    input wire logic                    rampActive,              // ramping
    input wire logic                    alarmActive,             // uncleared alarm
    input wire logic [NUM_OUT_FUNC-1:0] otherFuncs,              // other functions
    input wire logic [15:0]             freqOffset,              // applied offset
    input wire logic                    useTerminalSource,       // forced sources
    input wire logic [1:0]              frequency_source_select, // freq source
    input wire logic [1:0]              run_source_select,       // run source
    input wire logic                    motorOff,                // output shut off
    input wire logic                    forward_run_input,       // forward
    input wire logic                    reverse_run_input,       // reverse
    input wire logic                    trip_reset_input,        // trip reset
    input wire logic                    ocOut,                   // oc level
    input wire logic                    relayOut                 // relay level
);
    logic [12:0] cfg_ff;
    logic [11:0] fn;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // shadow of the output selectors, mirrors only completed writes
    always_ff @(posedge core_clk or negedge nrst)
        if (!nrst)
            cfg_ff <= 13'h1501;
        else if (psel && penable && pready && pwrite && paddr == OFS_OUT_CFG)
            cfg_ff <= pwdata[12:0];

    assign fn = {otherFuncs[11:6], alarmActive, otherFuncs[4:2],
                 outputRunning & ~rampActive, otherFuncs[0]};

    function automatic logic lvl(input logic [11:0] f, input logic [3:0] s, input logic p);
        return p ~^ ((s < 4'hC) && f[s]);
    endfunction

    chk_apb_zero_wait: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_ready_pulse: assert property (pready |-> (psel && penable) ##1 !pready)
        else $error("pready outside one access cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_fwd_rev_map: assert property ($past(nrst) |-> forward_run_input == $past(terminalIn[0])
        && reverse_run_input == $past(terminalIn[1]))
        else $error("terminals 1 and 2 not forward and reverse");
    chk_safe_stop_cut: assert property ($past(nrst) |->
        motorOff == $past(safe_stop_switch && !terminalIn[2]))
        else $error("motor shut-off not tied to safe stop");
    chk_switch_reset: assert property ($past(nrst && safe_stop_switch) |->
        trip_reset_input == $past(terminalIn[3]))
        else $error("terminal 4 not trip reset with switch on");
    chk_forced_src: assert property (useTerminalSource |->
        frequency_source_select == 2'h1 && run_source_select == 2'h1)
        else $error("forced sources not terminals");
    chk_oc_level: assert property ($past(nrst) |->
        ocOut == $past(lvl(fn, cfg_ff[3:0], cfg_ff[4])))
        else $error("oc level wrong");
    chk_relay_level: assert property ($past(nrst) |->
        relayOut == $past(lvl(fn, cfg_ff[11:8], cfg_ff[12])))
        else $error("relay level wrong");
    chk_offset_cause: assert property (freqOffset != 16'h0000 |-> $past(|terminalIn[4:2]))
        else $error("offset without active input");

    cover property (pready && pslverr);
    cover property (motorOff && safe_stop_switch);
    cover property (useTerminalSource);
endmodule

bind drive_terminal_function_map term_map_checker u_chk (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .terminalIn(terminalIn), .safe_stop_switch(safe_stop_switch),
    .outputRunning(outputRunning), .rampActive(rampActive), .alarmActive(alarmActive),
    .otherFuncs(otherFuncs), .freqOffset(freqOffset), .useTerminalSource(useTerminalSource),
    .frequency_source_select(frequency_source_select), .run_source_select(run_source_select),
    .motorOff(motorOff), .forward_run_input(forward_run_input),
    .reverse_run_input(reverse_run_input), .trip_reset_input(trip_reset_input),
    .ocOut(ocOut), .relayOut(relayOut));
